// File: bmc_cc_line_phy.sv
// biphase-mark transmitter and receiver for the configuration channel
// Notes on behaviour
// - every bit period starts with a level change on the line.
// - a one adds a change at half period, a zero does not.
// - high and low time over a packet differ by at most half a bit.
// - a message starts by driving low before the first coded edge.
// - after the last bit one more closing edge is sent.
// - the driver is enabled only while sending, else released.
// - only one party drives the shared wire; the transmitter enables its driver without checking for the partner.
// - only one of the two channel pins carries messages at a time.
// - the active pin follows the detected cable orientation.
`timescale 1ns/100ps
`include "bmc_cc_line_phy_cfg.svh"
module bmc_cc_line_phy #(
    parameter int HALF_CYC = `BMC_HALF_CYC,
    parameter int THRESH_CYC = `BMC_THRESH_CYC,
    parameter int IDLE_CYC = `BMC_IDLE_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cfgChannelPinSel,
    input wire logic txValid,
    output logic txReady,
    input wire logic txData,
    input wire logic txLast,
    output logic txBusy,
    input wire logic cfgChannelPinAIn,
    output logic cfgChannelPinAOut,
    output logic cfgChannelPinAOeN,
    input wire logic cfgChannelPinBIn,
    output logic cfgChannelPinBOut,
    output logic cfgChannelPinBOeN,
    output logic rxValid,
    output logic rxData,
    output logic rxActive
);
    localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);
    localparam logic [15:0] THRESH = 16'(THRESH_CYC);
    localparam logic [15:0] IDLE = 16'(IDLE_CYC);

    ////////////////////////////////////////////////////////////////////
    // input buffer: bit and last flag
    logic bufValid, bufReady;
    logic [1:0] bufData;

    bmc_skid_buffer #(.WIDTH(2)) u_buf (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .inValid(txValid),
        .inReady(txReady),
        .inData({txLast, txData}),
        .outValid(bufValid),
        .outReady(bufReady),
        .outData(bufData)
    );

    ////////////////////////////////////////////////////////////////////
    // transmitter
    bmc_cc_line_phy_pkg::tx_state_t txState_reg, txState_next;
    logic [15:0] txCnt_reg, txCnt_next;
    logic txLevel_reg, txLevel_next;
    logic txHalf_reg, txHalf_next;
    logic curBit_reg, curBit_next;
    logic curLast_reg, curLast_next;
    logic drive_reg, drive_next;
    logic pinSel_reg, pinSel_next;
    logic pinAOeN_reg, pinAOeN_next;
    logic pinBOeN_reg, pinBOeN_next;
    logic halfDone;

    assign halfDone = (txCnt_reg == HALF_M1);

    always_comb begin
        txState_next = txState_reg;
        txCnt_next = halfDone ? 16'h0000 : txCnt_reg + 16'h0001;
        txLevel_next = txLevel_reg;
        txHalf_next = txHalf_reg;
        curBit_next = curBit_reg;
        curLast_next = curLast_reg;
        drive_next = drive_reg;
        pinSel_next = pinSel_reg;
        bufReady = 1'b0;
        case (txState_reg)
            bmc_cc_line_phy_pkg::TX_IDLE: begin
                txCnt_next = 16'h0000;
                drive_next = 1'b0;
                pinSel_next = cfgChannelPinSel;
                if (bufValid) begin
                    txState_next = bmc_cc_line_phy_pkg::TX_LEAD;
                    txLevel_next = 1'b0;
                    drive_next = 1'b1;
                end
            end
            bmc_cc_line_phy_pkg::TX_LEAD: begin
                if (halfDone) begin
                    bufReady = 1'b1;
                    curBit_next = bufData[0];
                    curLast_next = bufData[1];
                    txLevel_next = ~txLevel_reg;
                    txHalf_next = 1'b0;
                    txState_next = bmc_cc_line_phy_pkg::TX_BITS;
                end
            end
            bmc_cc_line_phy_pkg::TX_BITS: begin
                if (halfDone && !txHalf_reg) begin
                    txHalf_next = 1'b1;
                    if (curBit_reg) begin
                        txLevel_next = ~txLevel_reg;
                    end
                end else if (halfDone) begin
                    txHalf_next = 1'b0;
                    txLevel_next = ~txLevel_reg;
                    if (curLast_reg) begin
                        txState_next = bmc_cc_line_phy_pkg::TX_CLOSE;
                    end else if (bufValid) begin
                        bufReady = 1'b1;
                        curBit_next = bufData[0];
                        curLast_next = bufData[1];
                    end else begin
                        // underrun: close the packet rather than stall
                        txState_next = bmc_cc_line_phy_pkg::TX_CLOSE;
                    end
                end
            end
            bmc_cc_line_phy_pkg::TX_CLOSE: begin
                // hold closing level half a bit, then release
                if (halfDone) begin
                    drive_next = 1'b0;
                    txState_next = bmc_cc_line_phy_pkg::TX_IDLE;
                end
            end
            default: begin
                txState_next = bmc_cc_line_phy_pkg::TX_IDLE;
                drive_next = 1'b0;
            end
        endcase
        pinAOeN_next = ~(drive_next && !pinSel_next);
        pinBOeN_next = ~(drive_next && pinSel_next);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            txState_reg <= bmc_cc_line_phy_pkg::TX_IDLE;
            txCnt_reg <= 16'h0000;
            txLevel_reg <= `BMC_LINE_IDLE;
            txHalf_reg <= 1'b0;
            curBit_reg <= 1'b0;
            curLast_reg <= 1'b0;
            drive_reg <= 1'b0;
            pinSel_reg <= 1'b0;
            pinAOeN_reg <= 1'b1;
            pinBOeN_reg <= 1'b1;
        end else begin
            txState_reg <= txState_next;
            txCnt_reg <= txCnt_next;
            txLevel_reg <= txLevel_next;
            txHalf_reg <= txHalf_next;
            curBit_reg <= curBit_next;
            curLast_reg <= curLast_next;
            drive_reg <= drive_next;
            pinSel_reg <= pinSel_next;
            pinAOeN_reg <= pinAOeN_next;
            pinBOeN_reg <= pinBOeN_next;
        end
    end

    // one pin at a time, chosen by orientation
    assign cfgChannelPinAOut = txLevel_reg;
    assign cfgChannelPinBOut = txLevel_reg;
    assign cfgChannelPinAOeN = pinAOeN_reg;
    assign cfgChannelPinBOeN = pinBOeN_reg;
    assign txBusy = drive_reg;

    ////////////////////////////////////////////////////////////////////
    // receiver
    logic rxLine, rxEdge;
    logic rxPrev_reg, rxPrev_next;
    logic [15:0] rxCnt_reg, rxCnt_next;
    logic rxHalfSeen_reg, rxHalfSeen_next;
    logic rxValid_reg, rxValid_next;
    logic rxData_reg, rxData_next;
    logic rxActive_reg, rxActive_next;

    assign rxLine = pinSel_reg ? cfgChannelPinBIn : cfgChannelPinAIn;
    assign rxEdge = (rxLine != rxPrev_reg) && !drive_reg;

    always_comb begin
        rxPrev_next = drive_reg ? `BMC_LINE_IDLE : rxLine; // own release
        rxValid_next = 1'b0;
        rxData_next = rxData_reg;
        rxHalfSeen_next = rxHalfSeen_reg;
        rxActive_next = rxActive_reg;
        rxCnt_next = (&rxCnt_reg) ? rxCnt_reg : rxCnt_reg + 16'h0001;
        if (rxEdge) begin
            rxCnt_next = 16'h0000;
            if (!rxActive_reg) begin
                // first edge only opens the frame, tolerant of loss
                rxActive_next = 1'b1;
                rxHalfSeen_next = 1'b0;
            end else if (rxCnt_reg >= THRESH) begin
                rxValid_next = 1'b1;
                rxData_next = 1'b0;
                rxHalfSeen_next = 1'b0;
            end else if (rxHalfSeen_reg) begin
                rxValid_next = 1'b1;
                rxData_next = 1'b1;
                rxHalfSeen_next = 1'b0;
            end else begin
                rxHalfSeen_next = 1'b1;
            end
        end else if (rxActive_reg && rxCnt_reg >= IDLE) begin
            rxActive_next = 1'b0;
            rxHalfSeen_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rxPrev_reg <= `BMC_LINE_IDLE;
            rxCnt_reg <= 16'h0000;
            rxHalfSeen_reg <= 1'b0;
            rxValid_reg <= 1'b0;
            rxData_reg <= 1'b0;
            rxActive_reg <= 1'b0;
        end else begin
            rxPrev_reg <= rxPrev_next;
            rxCnt_reg <= rxCnt_next;
            rxHalfSeen_reg <= rxHalfSeen_next;
            rxValid_reg <= rxValid_next;
            rxData_reg <= rxData_next;
            rxActive_reg <= rxActive_next;
        end
    end

    assign rxValid = rxValid_reg;
    assign rxData = rxData_reg;
    assign rxActive = rxActive_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    property p_bit_edge;
        txState_reg == bmc_cc_line_phy_pkg::TX_BITS && halfDone && txHalf_reg
            |=> txLevel_reg != $past(txLevel_reg);
    endproperty
    a_bit_edge: assert property (p_bit_edge) else $error("bit edge");
    property p_mid_edge;
        txState_reg == bmc_cc_line_phy_pkg::TX_BITS && halfDone && !txHalf_reg
            |=> (txLevel_reg != $past(txLevel_reg)) == $past(curBit_reg);
    endproperty
    a_mid_edge: assert property (p_mid_edge) else $error("mid edge");
    property p_lead_low;
        txState_reg == bmc_cc_line_phy_pkg::TX_IDLE && bufValid
            |=> drive_reg && !txLevel_reg;
    endproperty
    a_lead_low: assert property (p_lead_low) else $error("not low");
    property p_close;
        $rose(txState_reg == bmc_cc_line_phy_pkg::TX_CLOSE)
            |-> $changed(txLevel_reg) && drive_reg;
    endproperty
    a_close: assert property (p_close) else $error("no close edge");
    property p_release;
        txState_reg == bmc_cc_line_phy_pkg::TX_IDLE && !$past(bufValid)
            |-> cfgChannelPinAOeN && cfgChannelPinBOeN;
    endproperty
    a_release: assert property (p_release) else $error("drive idle");
    property p_one_pin;
        1'b1
            |-> cfgChannelPinAOeN || cfgChannelPinBOeN;
    endproperty
    a_one_pin: assert property (p_one_pin) else $error("two pins");
    property p_orient;
        drive_reg
            |-> cfgChannelPinBOeN == !pinSel_reg;
    endproperty
    a_orient: assert property (p_orient) else $error("wrong pin");
    property p_no_rx_while_tx;
        drive_reg
            |=> !rxValid_reg;
    endproperty
    a_no_rx_while_tx: assert property (p_no_rx_while_tx)
        else $error("rx while tx");
    property p_zero_gap;
        rxValid_reg && !rxData_reg
            |-> $past(rxCnt_reg) >= THRESH;
    endproperty
    a_zero_gap: assert property (p_zero_gap) else $error("short 0");
endmodule // bmc_cc_line_phy

// File: bmc_cc_line_phy_cfg.svh
// timing constants and reset values for the biphase-mark line coder
`ifndef BMC_CC_LINE_PHY_CFG_SVH
`define BMC_CC_LINE_PHY_CFG_SVH
`define BMC_CLK_HZ 50000000
`define BMC_BIT_RATE_HZ 300000
// half bit period in cycles, rounded down
`define BMC_HALF_CYC ((`BMC_CLK_HZ / `BMC_BIT_RATE_HZ) / 2)
`define BMC_FULL_CYC (2 * `BMC_HALF_CYC)
// decode threshold at three quarters of a bit
`define BMC_THRESH_CYC ((3 * `BMC_FULL_CYC) / 4)
// gap after which the receiver declares the line idle
`define BMC_IDLE_CYC (2 * `BMC_FULL_CYC)
`define BMC_LINE_IDLE 1'b1
`endif

// File: bmc_cc_line_phy_pkg.sv
// types for the biphase-mark line coder
package bmc_cc_line_phy_pkg;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_LEAD = 4'b0010,
        TX_BITS = 4'b0100,
        TX_CLOSE = 4'b1000
    } tx_state_t;
endpackage

// File: bmc_skid_buffer.sv
// two-entry valid/ready buffer
`timescale 1ns/100ps
module bmc_skid_buffer #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic rdPtr_reg;
    logic rdPtr_next;
    logic wrPtr_reg;
    logic wrPtr_next;
    logic inReady_reg;
    logic inReady_next;
    logic push;
    logic pop;

    assign inReady = inReady_reg;
    assign outValid = (count_reg != 2'd0);
    assign outData = mem_reg[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        mem_next = mem_reg;
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wrPtr_reg] = inData;
            wrPtr_next = ~wrPtr_reg;
        end
        if (pop) begin
            rdPtr_next = ~rdPtr_reg;
        end
        if (push && !pop) begin
            count_next = count_reg + 2'd1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'd1;
        end
        inReady_next = (count_next != 2'h2);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            count_reg <= 2'd0;
            rdPtr_reg <= 1'b0;
            wrPtr_reg <= 1'b0;
            inReady_reg <= 1'b1;
        end else begin
            mem_reg <= mem_next;
            count_reg <= count_next;
            rdPtr_reg <= rdPtr_next;
            wrPtr_reg <= wrPtr_next;
            inReady_reg <= inReady_next;
        end
    end
endmodule // bmc_skid_buffer

// File: bmc_partner_model.sv
// far-side controller model that sends coded frames on the shared wire
`timescale 1ns/100ps
module bmc_partner_model (
    input wire logic clk_sys,
    output logic partnerOut,
    output logic partnerOeN
);
    initial begin
        partnerOeN = 1'b1;
        partnerOut = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // skipLead starts high, so the receiver never sees a lead edge
    task automatic send(input bit bits[$], input int half,
        input bit skipLead);
        logic lvl;
        lvl = skipLead;
        @(posedge clk_sys);
        partnerOeN <= 1'b0;
        partnerOut <= lvl;
        repeat (half) @(posedge clk_sys);
        foreach (bits[i]) begin
            lvl = !lvl;
            partnerOut <= lvl;
            repeat (half) @(posedge clk_sys);
            lvl = lvl ^ bits[i];
            partnerOut <= lvl;
            repeat (half) @(posedge clk_sys);
        end
        lvl = !lvl;
        partnerOut <= lvl;
        repeat (half) @(posedge clk_sys);
        partnerOeN <= 1'b1;
        partnerOut <= !lvl;
    endtask
endmodule // bmc_partner_model

// File: testbench.sv
// self-checking bench for the biphase-mark line coder
`timescale 1ns/100ps
module testbench;
    localparam int H = 4;
    logic clk_sys, nrst, cfgChannelPinSel;
    logic txValid, txReady, txData, txLast, txBusy;
    logic aOut, aOeN, bOut, bOeN, lineA, lineB;
    logic rxValid, rxData, rxActive, pOut, pOeN;
    int fail_count;
    int tests_run;
    int sawFull;
    logic lv[$];
    logic rq[$];
    bit pk[$];
    ////////////////////////////////////////////////////////////
    bmc_cc_line_phy #(.HALF_CYC(H), .THRESH_CYC(6), .IDLE_CYC(16)) dut_u (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .cfgChannelPinSel(cfgChannelPinSel),
        .txValid(txValid),
        .txReady(txReady),
        .txData(txData),
        .txLast(txLast),
        .txBusy(txBusy),
        .cfgChannelPinAIn(lineA),
        .cfgChannelPinAOut(aOut),
        .cfgChannelPinAOeN(aOeN),
        .cfgChannelPinBIn(lineB),
        .cfgChannelPinBOut(bOut),
        .cfgChannelPinBOeN(bOeN),
        .rxValid(rxValid),
        .rxData(rxData),
        .rxActive(rxActive)
    );
    bmc_partner_model partner_u (
        .clk_sys(clk_sys),
        .partnerOut(pOut),
        .partnerOeN(pOeN)
    );
    // a released pin returns to the attach bias level
    assign lineA = !aOeN ? aOut
        : ((!pOeN && !cfgChannelPinSel) ? pOut : 1'b1);
    assign lineB = !bOeN ? bOut
        : ((!pOeN && cfgChannelPinSel) ? pOut : 1'b1);
    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // collect decoded bits and the levels driven on the chosen pin
    always @(negedge clk_sys) begin
        if (rxValid === 1'b1) begin
            rq.push_back(rxData);
        end
        if (pOeN === 1'b0) begin
            chk("device released", 2'b11, {aOeN, bOeN});
        end
        if ((cfgChannelPinSel ? bOeN : aOeN) === 1'b0) begin
            lv.push_back(cfgChannelPinSel ? bOut : aOut);
            chk("other pin", 1, cfgChannelPinSel ? aOeN : bOeN);
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic send_tx(input logic sel, input int n);
        int run;
        int worst;
        int b;
        pk.delete();
        lv.delete();
        for (int i = 0; i < n; i++) begin
            pk.push_back(i < 8 ? i[0] : 1'($urandom));
        end
        @(posedge clk_sys);
        cfgChannelPinSel <= sel;
        foreach (pk[j]) begin
            txValid <= 1'b1;
            txData <= pk[j];
            txLast <= (j == n - 1);
            @(negedge clk_sys);
            while (txReady !== 1'b1) begin
                sawFull = 1;
                @(negedge clk_sys);
            end
            @(posedge clk_sys);
        end
        txValid <= 1'b0;
        txLast <= 1'b0;
        while (txBusy !== 1'b0) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("drive length", 2 * H * (n + 1), lv.size());
        if (lv.size() == 2 * H * (n + 1)) begin
            run = 0;
            worst = 0;
            foreach (lv[k]) begin
                run += lv[k] ? 1 : -1;
                worst = (run > worst) ? run : ((-run > worst) ? -run : worst);
            end
            chk("disparity", H, worst);
            chk("lead level", 0, lv[0] | lv[H - 1]);
            foreach (pk[j]) begin
                b = H + 2 * H * j;
                chk("bit edge", 1, lv[b] ^ lv[b - 1]);
                chk("mid edge", pk[j], lv[b + H] ^ lv[b + H - 1]);
            end
            b = H + 2 * H * n;
            chk("closing edge", 1, lv[b] ^ lv[b - 1]);
        end
    endtask

    task automatic recv(input logic sel, input int half, input bit skip);
        bit bits[$];
        @(posedge clk_sys);
        cfgChannelPinSel <= sel;
        for (int i = 0; i < 16; i++) begin
            bits.push_back(i < 8 ? i[0] : 1'($urandom));
        end
        rq.delete();
        partner_u.send(bits, half, skip);
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("frame closed", 0, rxActive);
        chk("enough bits", 1, rq.size() >= 8);
        for (int i = 1; i <= 8; i++) begin
            chk("rx bit", bits[16 - i], rq[rq.size() - i]);
        end
        if (skip) begin
            chk("rx count", 16, rq.size());
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        close_out;
    end

    initial begin
        nrst = 1'b0;
        cfgChannelPinSel = 1'b0;
        txValid = 1'b0;
        txData = 1'b0;
        txLast = 1'b0;
        fail_count = 0;
        tests_run = 0;
        sawFull = 0;
        void'($urandom(91217));
        repeat (7) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("reset outputs", 7'h7c,
            {aOeN, bOeN, aOut, bOut, txReady, rxValid, rxActive});
        @(posedge clk_sys);
        nrst <= 1'b1;
        send_tx(1'b0, 24);
        send_tx(1'b1, 24);
        send_tx(1'b0, 9);
        chk("buffer refused", 1, sawFull);
        recv(1'b0, H, 1'b0);
        recv(1'b1, H + 1, 1'b1);
        recv(1'b0, H, 1'b1);
        send_tx(1'b1, 12);
        close_out;
    end
endmodule // testbench
